/* logic/rfmc_config_regs.sv */
// Radio carrier frequency and modem configuration register bank with AXI4-Lite slave
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module rfmc_config_regs
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [rfmc_pkg::RFMC_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [rfmc_pkg::RFMC_DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [rfmc_pkg::RFMC_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [rfmc_pkg::RFMC_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // Radio datapath configuration
    output rfmc_pkg::rfmc_cfg_s cfg,
    output rfmc_pkg::rfmc_derived_s derived
);
    import rfmc_pkg::*;

    // ==========================================================
    // Storage
    logic [5:0] word_high;
    logic [7:0] word_middle;
    logic [7:0] word_low;
    logic [7:0] bw_rate_exp;
    logic [7:0] rate_mant;
    logic [7:0] modem_mode;
    logic [RFMC_ADDR_W-1:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane0_q;

    // ==========================================================
    // Write decode
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire commit = !awready && !wready && !bvalid;
    wire wr_high = aw_addr_q == RFMC_ADDR_WORD_HIGH;
    wire wr_middle = aw_addr_q == RFMC_ADDR_WORD_MIDDLE;
    wire wr_low = aw_addr_q == RFMC_ADDR_WORD_LOW;
    wire wr_bw = aw_addr_q == RFMC_ADDR_BW_RATE_EXP;
    wire wr_mant = aw_addr_q == RFMC_ADDR_RATE_MANT;
    wire wr_mode = aw_addr_q == RFMC_ADDR_MODEM_MODE;
    wire wr_hit = wr_high || wr_middle || wr_low || wr_bw || wr_mant || wr_mode;
    wire wr_en = commit && w_lane0_q;

    // ==========================================================
    // Read decode
    wire ar_take = arvalid && arready;
    wire rd_high = araddr == RFMC_ADDR_WORD_HIGH;
    wire rd_middle = araddr == RFMC_ADDR_WORD_MIDDLE;
    wire rd_low = araddr == RFMC_ADDR_WORD_LOW;
    wire rd_bw = araddr == RFMC_ADDR_BW_RATE_EXP;
    wire rd_mant = araddr == RFMC_ADDR_RATE_MANT;
    wire rd_mode = araddr == RFMC_ADDR_MODEM_MODE;
    wire rd_hit = rd_high || rd_middle || rd_low || rd_bw || rd_mant || rd_mode;
    wire [7:0] high_view = {RFMC_HIGH_FIXED, word_high}; // RULE_08
    wire [7:0] rd_byte = rd_high ? high_view :
                         rd_middle ? word_middle :
                         rd_low ? word_low :
                         rd_bw ? bw_rate_exp :
                         rd_mant ? rate_mant :
                         rd_mode ? modem_mode : 8'h00;
    wire [RFMC_DATA_W-1:0] next_rdata = {24'h000000, rd_byte};
    wire [1:0] next_rresp = rd_hit ? RFMC_RESP_OKAY : RFMC_RESP_DECERR;

    // ==========================================================
    // Derived radio arithmetic
    wire [8:0] bw_div = {4'h0, 2'h0, RFMC_BW_MANT_BASE} + {7'h00, cfg.filter_bw_mantissa};
    wire [8:0] next_decim = (bw_div << RFMC_BW_DECIM_SHIFT) << cfg.filter_bw_exponent; // RULE_03
    wire [8:0] rate_mant9 = RFMC_RATE_HIDDEN_ONE + {1'h0, cfg.symbol_rate_mantissa_field};
    wire [23:0] next_rate = {15'h0000, rate_mant9} << cfg.symbol_rate_exponent; // RULE_05

    // ==========================================================
    // Write address and data capture
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awready <= 1'b1;
            aw_addr_q <= '0;
        end
        else if (aw_take)
        begin
            awready <= 1'b0;
            aw_addr_q <= awaddr;
        end
        else if (commit)
        begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wready <= 1'b1;
            w_data_q <= 8'h00;
            w_lane0_q <= 1'b0;
        end
        else if (w_take)
        begin
            wready <= 1'b0;
            w_data_q <= wdata[7:0];
            w_lane0_q <= wstrb[0];
        end
        else if (commit)
        begin
            wready <= 1'b1;
        end
    end

    // ==========================================================
    // Write response
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bvalid <= 1'b0;
            bresp <= RFMC_RESP_OKAY;
        end
        else if (commit)
        begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? RFMC_RESP_OKAY : RFMC_RESP_DECERR;
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Read channel
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RFMC_RESP_OKAY;
        end
        else if (ar_take)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
        else if (rvalid && rready)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Carrier base word bytes
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            word_high <= RFMC_RST_WORD_HIGH;
            word_middle <= RFMC_RST_WORD_MIDDLE;
            word_low <= RFMC_RST_WORD_LOW;
        end
        else if (wr_en)
        begin
            if (wr_high)
                word_high <= w_data_q[5:0]; // RULE_08
            if (wr_middle)
                word_middle <= w_data_q;
            if (wr_low)
                word_low <= w_data_q;
        end
    end

    // ==========================================================
    // Modem configuration bytes
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bw_rate_exp <= RFMC_RST_BW_RATE_EXP; // RULE_04
            rate_mant <= RFMC_RST_RATE_MANT;
            modem_mode <= RFMC_RST_MODEM_MODE; // RULE_07
        end
        else if (wr_en)
        begin
            if (wr_bw)
                bw_rate_exp <= w_data_q;
            if (wr_mant)
                rate_mant <= w_data_q;
            if (wr_mode)
                modem_mode <= w_data_q;
        end
    end

    // ==========================================================
    // Datapath outputs
    assign cfg.carrier_base_word = {high_view, word_middle, word_low}; // RULE_01 RULE_02
    assign cfg.filter_bw_exponent = bw_rate_exp[RFMC_BW_EXP_LSB +: 2]; // RULE_03
    assign cfg.filter_bw_mantissa = bw_rate_exp[RFMC_BW_MANT_LSB +: 2]; // RULE_03
    assign cfg.symbol_rate_exponent = bw_rate_exp[RFMC_RATE_EXP_LSB +: 4]; // RULE_04
    assign cfg.symbol_rate_mantissa_field = rate_mant; // RULE_05
    assign cfg.dc_block_bypass = modem_mode[RFMC_DC_BYPASS_BIT]; // RULE_06
    assign cfg.modulation_select = modem_mode[RFMC_MOD_SEL_LSB +: 3]; // RULE_07
    assign cfg.mode_low_bits = modem_mode[3:0];

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            derived <= '0;
        end
        else
        begin
            derived.decimation_ratio <= next_decim; // RULE_03
            derived.rate_numerator <= next_rate; // RULE_05
        end
    end

    // ==========================================================
    // Checks
    sequence s_commit_to(logic hit);
        commit && w_lane0_q && hit;
    endsequence

    property p_high_fixed;
        @(posedge sys_clk) disable iff (!reset_n)
        cfg.carrier_base_word[23:22] == 2'h1 && high_view[7:6] == 2'h1;
    endproperty
    a_high_fixed: assert property (p_high_fixed) else $error("high byte top bits changed"); // RULE_08

    property p_write_high;
        @(posedge sys_clk) disable iff (!reset_n)
        s_commit_to(wr_high) |=> cfg.carrier_base_word[21:16] == $past(w_data_q[5:0]);
    endproperty
    a_write_high: assert property (p_write_high) else $error("high byte write lost"); // RULE_01

    property p_write_low;
        @(posedge sys_clk) disable iff (!reset_n)
        s_commit_to(wr_low) |=> cfg.carrier_base_word[7:0] == $past(w_data_q)
            && $stable(cfg.carrier_base_word[23:8]);
    endproperty
    a_write_low: assert property (p_write_low) else $error("low byte write wrong"); // RULE_01

    property p_write_middle;
        @(posedge sys_clk) disable iff (!reset_n)
        s_commit_to(wr_middle) |=> cfg.carrier_base_word[15:8] == $past(w_data_q);
    endproperty
    a_write_middle: assert property (p_write_middle) else $error("middle byte write wrong"); // RULE_02

    property p_bw_fields;
        @(posedge sys_clk) disable iff (!reset_n)
        s_commit_to(wr_bw) |=> cfg.filter_bw_exponent == $past(w_data_q[7:6])
            && cfg.filter_bw_mantissa == $past(w_data_q[5:4]);
    endproperty
    a_bw_fields: assert property (p_bw_fields) else $error("bandwidth fields wrong"); // RULE_03

    property p_rate_exp;
        @(posedge sys_clk) disable iff (!reset_n)
        s_commit_to(wr_bw) |=> cfg.symbol_rate_exponent == $past(w_data_q[3:0]);
    endproperty
    a_rate_exp: assert property (p_rate_exp) else $error("rate exponent wrong"); // RULE_04

    property p_decim;
        @(posedge sys_clk) disable iff (!reset_n)
        reset_n && $stable(cfg.filter_bw_mantissa) && $stable(cfg.filter_bw_exponent) |=>
            derived.decimation_ratio == (9'((8 * (4 + $past(cfg.filter_bw_mantissa)))
                << $past(cfg.filter_bw_exponent)));
    endproperty
    a_decim: assert property (p_decim) else $error("decimation ratio wrong"); // RULE_03

    property p_rate_num;
        @(posedge sys_clk) disable iff (!reset_n)
        reset_n |=> derived.rate_numerator == (24'(256 + $past(cfg.symbol_rate_mantissa_field))
            << $past(cfg.symbol_rate_exponent));
    endproperty
    a_rate_num: assert property (p_rate_num) else $error("rate numerator wrong"); // RULE_05

    property p_mode_fields;
        @(posedge sys_clk) disable iff (!reset_n)
        s_commit_to(wr_mode) |=> cfg.dc_block_bypass == $past(w_data_q[7])
            && cfg.modulation_select == $past(w_data_q[6:4]);
    endproperty
    a_mode_fields: assert property (p_mode_fields) else $error("mode fields wrong"); // RULE_06 RULE_07

    sequence s_read_high;
        ar_take && rd_high;
    endsequence

    property p_read_high;
        @(posedge sys_clk) disable iff (!reset_n)
        s_read_high |=> rvalid && rdata[7:6] == 2'h1 && rdata[31:8] == 24'h000000;
    endproperty
    a_read_high: assert property (p_read_high) else $error("high byte readback wrong"); // RULE_08

    property p_write_mant;
        @(posedge sys_clk) disable iff (!reset_n)
        s_commit_to(wr_mant) |=> cfg.symbol_rate_mantissa_field == $past(w_data_q);
    endproperty
    a_write_mant: assert property (p_write_mant) else $error("rate mantissa write wrong"); // RULE_05

    property p_lane0_guard;
        @(posedge sys_clk) disable iff (!reset_n)
        commit && !w_lane0_q |=> $stable(cfg);
    endproperty
    a_lane0_guard: assert property (p_lane0_guard) else $error("write without lane 0 changed state"); // RULE_01

    property p_write_answer;
        @(posedge sys_clk) disable iff (!reset_n)
        commit |=> bvalid && bresp == ($past(wr_hit) ? RFMC_RESP_OKAY : RFMC_RESP_DECERR);
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write response wrong");

    property p_read_resp;
        @(posedge sys_clk) disable iff (!reset_n)
        ar_take |=> rvalid && rresp == ($past(rd_hit) ? RFMC_RESP_OKAY : RFMC_RESP_DECERR)
            && ($past(rd_hit) || rdata == 32'h00000000);
    endproperty
    a_read_resp: assert property (p_read_resp) else $error("read response wrong");

    sequence s_read_of(logic hit);
        ar_take && hit;
    endsequence

    property p_read_bw;
        @(posedge sys_clk) disable iff (!reset_n)
        s_read_of(rd_bw) |=> rdata[7:0] == {$past(cfg.filter_bw_exponent), $past(cfg.filter_bw_mantissa),
            $past(cfg.symbol_rate_exponent)};
    endproperty
    a_read_bw: assert property (p_read_bw) else $error("bandwidth readback wrong"); // RULE_03 RULE_04

    property p_read_mant;
        @(posedge sys_clk) disable iff (!reset_n)
        s_read_of(rd_mant) |=> rdata[7:0] == $past(cfg.symbol_rate_mantissa_field);
    endproperty
    a_read_mant: assert property (p_read_mant) else $error("rate mantissa readback wrong"); // RULE_05

    property p_read_mode;
        @(posedge sys_clk) disable iff (!reset_n)
        s_read_of(rd_mode) |=> rdata[7:0] == {$past(cfg.dc_block_bypass), $past(cfg.modulation_select),
            $past(cfg.mode_low_bits)};
    endproperty
    a_read_mode: assert property (p_read_mode) else $error("mode readback wrong"); // RULE_06 RULE_07

endmodule

/* logic/rfmc_pkg.sv */
// Constants, field layouts and carrier types of the radio frequency/modem config bank
// Operation
// RULE_01 - Three bytes form 24-bit carrier base word
// RULE_02 - Word counts carrier steps of reference over 2^16
// RULE_03 - Bandwidth exponent 7:6, mantissa 5:4 set decimation
// RULE_04 - Symbol rate exponent in 3:0, reset 1100
// RULE_05 - Rate is (256+mantissa) shifted by exponent
// RULE_06 - Mode bit 7 bypasses DC blocking filter
// RULE_07 - Modulation select in 6:4, reset 2-FSK
// RULE_08 - High byte top bits read-only, read 01
package rfmc_pkg;

    // ==========================================================
    // Bus geometry
    localparam int RFMC_ADDR_W = 18;
    localparam int RFMC_DATA_W = 32;

    // ==========================================================
    // Register indices and byte addresses (byte address is four times the index)
    localparam logic [15:0] RFMC_IDX_WORD_HIGH = 16'hdf09;
    localparam logic [15:0] RFMC_IDX_WORD_MIDDLE = 16'hdf0a;
    localparam logic [15:0] RFMC_IDX_WORD_LOW = 16'hdf0b;
    localparam logic [15:0] RFMC_IDX_BW_RATE_EXP = 16'hdf0c;
    localparam logic [15:0] RFMC_IDX_RATE_MANT = 16'hdf0d;
    localparam logic [15:0] RFMC_IDX_MODEM_MODE = 16'hdf0e;
    localparam logic [17:0] RFMC_ADDR_WORD_HIGH = {RFMC_IDX_WORD_HIGH, 2'h0};
    localparam logic [17:0] RFMC_ADDR_WORD_MIDDLE = {RFMC_IDX_WORD_MIDDLE, 2'h0};
    localparam logic [17:0] RFMC_ADDR_WORD_LOW = {RFMC_IDX_WORD_LOW, 2'h0};
    localparam logic [17:0] RFMC_ADDR_BW_RATE_EXP = {RFMC_IDX_BW_RATE_EXP, 2'h0};
    localparam logic [17:0] RFMC_ADDR_RATE_MANT = {RFMC_IDX_RATE_MANT, 2'h0};
    localparam logic [17:0] RFMC_ADDR_MODEM_MODE = {RFMC_IDX_MODEM_MODE, 2'h0};

    // ==========================================================
    // Reset values
    localparam logic [1:0] RFMC_HIGH_FIXED = 2'h1;
    localparam logic [5:0] RFMC_RST_WORD_HIGH = 6'h1e;
    localparam logic [7:0] RFMC_RST_WORD_MIDDLE = 8'hc4;
    localparam logic [7:0] RFMC_RST_WORD_LOW = 8'hec;
    localparam logic [7:0] RFMC_RST_BW_RATE_EXP = 8'h8c;
    localparam logic [7:0] RFMC_RST_RATE_MANT = 8'h22;
    localparam logic [7:0] RFMC_RST_MODEM_MODE = 8'h02;

    // ==========================================================
    // Field positions
    localparam int RFMC_BW_EXP_LSB = 6;
    localparam int RFMC_BW_MANT_LSB = 4;
    localparam int RFMC_RATE_EXP_LSB = 0;
    localparam int RFMC_DC_BYPASS_BIT = 7;
    localparam int RFMC_MOD_SEL_LSB = 4;

    // ==========================================================
    // Modulation codes and rate arithmetic
    localparam logic [2:0] RFMC_MOD_2FSK = 3'h0;
    localparam logic [2:0] RFMC_MOD_GFSK = 3'h1;
    localparam logic [2:0] RFMC_MOD_ASK_OOK = 3'h3;
    localparam logic [2:0] RFMC_MOD_MSK = 3'h7;
    localparam logic [8:0] RFMC_RATE_HIDDEN_ONE = 9'h100;
    localparam logic [2:0] RFMC_BW_MANT_BASE = 3'h4;
    localparam int RFMC_BW_DECIM_SHIFT = 3;

    // ==========================================================
    // AXI response codes
    localparam logic [1:0] RFMC_RESP_OKAY = 2'h0;
    localparam logic [1:0] RFMC_RESP_DECERR = 2'h3;

    // ==========================================================
    // Carriers toward the radio datapath
    typedef struct packed {
        logic [23:0] carrier_base_word;
        logic [1:0] filter_bw_exponent;
        logic [1:0] filter_bw_mantissa;
        logic [3:0] symbol_rate_exponent;
        logic [7:0] symbol_rate_mantissa_field;
        logic dc_block_bypass;
        logic [2:0] modulation_select;
        logic [3:0] mode_low_bits;
    } rfmc_cfg_s;

    typedef struct packed {
        logic [8:0] decimation_ratio;
        logic [23:0] rate_numerator;
    } rfmc_derived_s;

endpackage

/* verification/rfmc_testbench.sv */
// Self-checking bench of the radio carrier and modem configuration register bank
`timescale 1ns/1ps
module testbench;
    import rfmc_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic [17:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    rfmc_cfg_s cfg;
    rfmc_derived_s derived;
    logic [7:0] model [6];
    logic [17:0] addr_tab [6] = '{RFMC_ADDR_WORD_HIGH, RFMC_ADDR_WORD_MIDDLE, RFMC_ADDR_WORD_LOW,
        RFMC_ADDR_BW_RATE_EXP, RFMC_ADDR_RATE_MANT, RFMC_ADDR_MODEM_MODE};
    int errors = 0;
    int samples_checked = 0;

    always #2.5 sys_clk = ~sys_clk;

    rfmc_config_regs DUT (.sys_clk(sys_clk), .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .cfg(cfg), .derived(derived));

    // ==========================================================
    // Checking and expectations
    task automatic check(input string name, input logic [48:0] seen, input logic [48:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] exp_read(int i);
        return (i == 0) ? {2'b01, model[0][5:0]} : model[i];
    endfunction

    function automatic logic [32:0] exp_derived();
        logic [8:0] dec;
        logic [23:0] rate;
        dec = 9'((8 * (4 + model[3][5:4])) << model[3][7:6]);
        rate = 24'((256 + model[4]) << model[3][3:0]);
        return {dec, rate};
    endfunction

    task automatic print_verdict();
        if (errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // Bus master
    task automatic axi_write(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] resp);
        logic ap, wp, ta, tw, got;
        int n;
        ap = 1'b1;
        wp = 1'b1;
        got = 1'b0;
        n = 0;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        while ((ap || wp) && n < 50)
        begin
            @(negedge sys_clk);
            ta = ap && awready === 1'b1;
            tw = wp && wready === 1'b1;
            @(posedge sys_clk);
            awvalid <= ap && !ta;
            wvalid <= wp && !tw;
            ap = ap && !ta;
            wp = wp && !tw;
            n++;
        end
        while (!got && n < 100)
        begin
            @(negedge sys_clk);
            got = bvalid === 1'b1;
            resp = bresp;
            @(posedge sys_clk);
            n++;
        end
        if (!got)
            check("bvalid", 0, 1);
    endtask

    task automatic axi_read(input logic [17:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ta, got;
        int n;
        ta = 1'b0;
        got = 1'b0;
        n = 0;
        arvalid <= 1'b1;
        araddr <= a;
        while (!ta && n < 50)
        begin
            @(negedge sys_clk);
            ta = arready === 1'b1;
            @(posedge sys_clk);
            arvalid <= !ta;
            n++;
        end
        while (!got && n < 100)
        begin
            @(negedge sys_clk);
            got = rvalid === 1'b1;
            d = rdata;
            resp = rresp;
            @(posedge sys_clk);
            n++;
        end
        if (!got)
            check("rvalid", 0, 1);
    endtask

    task automatic check_reg(int i);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(addr_tab[i], d, r);
        check("rdata", d, {24'h0, exp_read(i)});
        check("rresp", r, RFMC_RESP_OKAY);
        check("carrier_base_word", cfg.carrier_base_word, {2'b01, model[0][5:0], model[1], model[2]});
        check("cfg", cfg, {2'b01, model[0][5:0], model[1], model[2], model[3], model[4], model[5]});
        check("derived", derived, exp_derived());
    endtask

    // ==========================================================
    // Test sequence
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [3:0] s;
        int i;
        void'($urandom(78));
        model = '{8'h5e, 8'hc4, 8'hec, 8'h8c, 8'h22, 8'h02};
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        for (i = 0; i < 6; i++)
            check_reg(i);
        axi_write(addr_tab[0], 32'hffffffff, 4'hf, r);
        model[0] = 8'hff;
        check_reg(0);
        axi_write(addr_tab[0], 32'h0, 4'hf, r);
        model[0] = 8'h00;
        check_reg(0);
        axi_write(addr_tab[1], 32'h55, 4'he, r);
        check("bresp", r, RFMC_RESP_OKAY);
        check_reg(1);
        axi_write(RFMC_ADDR_MODEM_MODE + 18'h4, 32'h77, 4'hf, r);
        check("bresp", r, RFMC_RESP_DECERR);
        axi_read(18'h0, d, r);
        check("rresp", r, RFMC_RESP_DECERR);
        check("rdata", d, 0);
        for (i = 3; i < 5; i++)
        begin
            axi_write(addr_tab[i], 32'hff, 4'h1, r);
            model[i] = 8'hff;
        end
        check_reg(4);
        for (i = 0; i < 16; i++)
        begin
            d = $urandom;
            axi_write(addr_tab[5], {d[31:8], i[3:0], d[3:0]}, 4'h1, r);
            model[5] = {i[3:0], d[3:0]};
            check_reg(5);
        end
        repeat (40)
        begin
            i = $urandom_range(0, 5);
            d = $urandom;
            s = 4'($urandom);
            axi_write(addr_tab[i], d, s, r);
            check("bresp", r, RFMC_RESP_OKAY);
            if (s[0])
                model[i] = d[7:0];
            check_reg(i);
        end
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        model = '{8'h5e, 8'hc4, 8'hec, 8'h8c, 8'h22, 8'h02};
        @(posedge sys_clk);
        for (i = 0; i < 6; i++)
            check_reg(i);
        print_verdict();
    end

    initial
    begin
        #100000;
        errors++;
        print_verdict();
    end
endmodule
